// ===== logic/aasp_pkg.sv
// Shared constants, types and helpers of the angle sensor SPI host controller.
package aasp_pkg;
  typedef logic [15:0] aasp_word_t;
  typedef logic [4:0]  aasp_bits_t;
  typedef logic [7:0]  aasp_cnt8_t;
  typedef logic [2:0]  aasp_code_t;

  // Core clock period and the link timing figures in nanoseconds.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_CSL_NS       = 100; // Chip select fall to first clock fall, least.
  localparam int T_CSH_NS       = 20;  // Last clock rise to chip select rise, least.
  localparam int T_IDLE_NS      = 40;  // Idle time between two frames, least.
  localparam int T_SCLK_HALF_NS = 20;  // Each clock level, least.
  localparam int SYNC_STAGES    = 2;

  // Least times round up to whole cycles, never below one.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CSL_CYC       = ns_to_cyc(T_CSL_NS);
  localparam int CSH_CYC       = ns_to_cyc(T_CSH_NS);
  localparam int IDLE_CYC      = ns_to_cyc(T_IDLE_NS);
  localparam int HALF_MIN_CYC  = ns_to_cyc(T_SCLK_HALF_NS);
  // The data-in sample path has a two-stage synchroniser, so a half period is at least two.
  localparam int SCLK_HALF_DEF = (HALF_MIN_CYC < SYNC_STAGES) ? SYNC_STAGES : HALF_MIN_CYC;
  localparam int NVM_GUARD_CYC = 4;
  localparam int FRAME_BITS    = 16;
  localparam aasp_bits_t FULL_BITS = 5'h10;

  // Command codes and frame field positions.
  localparam aasp_code_t CODE_ANGLE     = 3'h0;
  localparam aasp_code_t CODE_CLEAR     = 3'h1;
  localparam aasp_code_t CODE_READ      = 3'h2;
  localparam aasp_code_t CODE_WRITE     = 3'h4;
  localparam aasp_code_t CODE_RESTORE   = 3'h5;
  localparam aasp_code_t CODE_STORE_ALL = 3'h6;
  localparam aasp_code_t CODE_STORE_ONE = 3'h7;
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;

  typedef enum logic [2:0] {
    OP_ANGLE, OP_READ, OP_WRITE, OP_STORE_ONE, OP_STORE_ALL, OP_RESTORE, OP_CLEAR
  } aasp_op_e;

  function automatic logic is_nvm_op(input aasp_op_e op);
    return (op == OP_STORE_ONE) || (op == OP_STORE_ALL) || (op == OP_RESTORE);
  endfunction

  function automatic logic is_two_frame(input aasp_op_e op);
    return (op == OP_READ) || (op == OP_WRITE);
  endfunction
endpackage

// ===== logic/aasp_frame_if.sv
// Frame request and result carrier between the controller and the frame engine.
`timescale 1ns/1ns
interface aasp_frame_if;
  import aasp_pkg::*;
  logic       start;
  aasp_bits_t nbits;
  aasp_word_t tx;
  aasp_word_t rx;
  logic       done;
  logic       miso_s;
  modport ctrl   (output start, nbits, tx, miso_s, input rx, done);
  modport engine (input start, nbits, tx, miso_s, output rx, done);
endinterface

// ===== logic/aasp_pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the core clock.
`timescale 1ns/1ns
module aasp_pin_sync #(
  parameter int W = 2 // Number of pins.
) (
  input  wire logic         ref_clk_in, // Core clock.
  input  wire logic         rst_in,     // Synchronous reset, active high.
  input  wire logic [W-1:0] pins_in,    // Raw pin levels.
  output logic      [W-1:0] sync_out    // Synchronised levels.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aasp_sync_s;

  aasp_sync_s s_reg;
  aasp_sync_s s_next;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb
  begin
    s_next.s1 = pins_in;
    s_next.s2 = s_reg.s1;
  end

  // Both stages clear on reset.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.s2;
endmodule

// ===== logic/aasp_frame_engine.sv
// Serial frame engine: drives chip select, clock and data-out for one frame.
`timescale 1ns/1ns
module aasp_frame_engine #(
  parameter int SCLK_HALF     = 2,   // Core cycles per clock level, two or more.
  parameter bit CLK_IDLE_HIGH = 1'b0 // Clock idle level: low for mode 0, high for mode 3.
) (
  input  wire logic    ref_clk_in,   // Core clock.
  input  wire logic    rst_in,       // Synchronous reset, active high.
  aasp_frame_if.engine fr,           // Frame request and result.
  output logic         spi_cs_n_out, // Chip select, active low.
  output logic         spi_sclk_out, // Serial clock.
  output logic         spi_mosi_out  // Serial data to the sensor.
);
  import aasp_pkg::*;

  typedef enum logic [2:0] {F_IDLE, F_SETUP, F_LOW, F_HIGH, F_HOLD, F_GAP} aasp_fph_e;
  typedef struct packed {
    aasp_fph_e  ph;
    aasp_cnt8_t cnt;
    aasp_bits_t bits;
    aasp_bits_t sent;
    aasp_bits_t rises;
    aasp_word_t tx;
    aasp_word_t rx;
    logic       cs_n;
    logic       sclk;
    logic       done;
  } aasp_eng_s;

  localparam aasp_cnt8_t CNT_ONE = 8'h01;
  localparam aasp_cnt8_t HALF_C  = aasp_cnt8_t'(SCLK_HALF);
  localparam aasp_cnt8_t CSL_C   = aasp_cnt8_t'(CSL_CYC);
  localparam aasp_cnt8_t CSH_C   = aasp_cnt8_t'(CSH_CYC);
  localparam aasp_cnt8_t IDLE_C  = aasp_cnt8_t'(IDLE_CYC);
  localparam aasp_bits_t BIT_ONE = 5'h01;
  localparam aasp_eng_s  ENG_RST = '{ph: F_IDLE, cnt: CNT_ONE, bits: FULL_BITS, sent: '0,
                                     rises: '0, tx: '0, rx: '0, cs_n: 1'b1,
                                     sclk: CLK_IDLE_HIGH, done: 1'b0};

  aasp_eng_s s_reg;
  aasp_eng_s s_next;
  logic      last;

  // Each bit is a low level then a high level: data-out changes as the clock falls
  // and data-in is taken at the end of the high level, so one sequence serves both modes.
  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    last        = (s_reg.cnt == CNT_ONE);
    if (!last)
    begin
      s_next.cnt = s_reg.cnt - CNT_ONE;
    end
    unique case (s_reg.ph)
      F_IDLE:
      begin
        if (fr.start)
        begin
          s_next.ph    = F_SETUP;
          s_next.cnt   = CSL_C;
          s_next.bits  = fr.nbits;
          s_next.sent  = '0;
          s_next.rises = '0;
          s_next.tx    = fr.tx;
          s_next.rx    = '0;
          s_next.cs_n  = 1'b0;
        end
      end
      F_SETUP:
      begin
        if (last)
        begin
          s_next.ph   = F_LOW;
          s_next.cnt  = HALF_C;
          s_next.sclk = 1'b0;
        end
      end
      F_LOW:
      begin
        if (last)
        begin
          s_next.ph    = F_HIGH;
          s_next.cnt   = HALF_C;
          s_next.sclk  = 1'b1;
          s_next.rises = s_reg.rises + BIT_ONE;
        end
      end
      F_HIGH:
      begin
        if (last)
        begin
          s_next.rx   = {s_reg.rx[FRAME_BITS-2:0], fr.miso_s};
          s_next.sent = s_reg.sent + BIT_ONE;
          if (s_next.sent == s_reg.bits)
          begin
            s_next.ph  = F_HOLD;
            s_next.cnt = CSH_C;
          end
          else
          begin
            s_next.ph   = F_LOW;
            s_next.cnt  = HALF_C;
            s_next.sclk = 1'b0;
            s_next.tx   = {s_reg.tx[FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      F_HOLD:
      begin
        if (last)
        begin
          s_next.ph   = F_GAP;
          s_next.cnt  = IDLE_C;
          s_next.cs_n = 1'b1;
          s_next.sclk = CLK_IDLE_HIGH;
        end
      end
      F_GAP:
      begin
        if (last)
        begin
          s_next.ph   = F_IDLE;
          s_next.done = 1'b1;
        end
      end
      default:
      begin
        s_next = ENG_RST;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s_reg <= ENG_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign spi_cs_n_out = s_reg.cs_n;
  assign spi_sclk_out = s_reg.sclk;
  assign spi_mosi_out = s_reg.tx[FRAME_BITS-1];
  assign fr.rx        = s_reg.rx;
  assign fr.done      = s_reg.done;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // A frame carries exactly as many clock rises as were asked for.
  AST_FRAME_RISES:
    assert property ($rose(spi_cs_n_out) |-> s_reg.rises == s_reg.bits)
    else $error("frame clock count differs from request");

  // Data-out holds still while the clock is high, where the sensor samples it.
  // In mode 3 the clock already idles high as chip select falls and loads the first bit,
  // so the cycle of that fall is left out.
  AST_MOSI_STEADY:
    assert property (!spi_cs_n_out && $past(!spi_cs_n_out) && spi_sclk_out
                     && $past(spi_sclk_out) |-> $stable(spi_mosi_out))
    else $error("data-out moved while the clock was high");
endmodule

// ===== logic/aasp_host_ctrl.sv
// Host controller that runs angle, register and memory commands on the sensor's SPI port.
`timescale 1ns/1ns
module aasp_host_ctrl #(
  parameter int SCLK_HALF     = aasp_pkg::SCLK_HALF_DEF, // Core cycles per clock level.
  parameter bit CLK_IDLE_HIGH = 1'b0                     // Low: mode 0, high: mode 3.
) (
  input  wire logic              ref_clk_in,         // Core clock, 10 MHz.
  input  wire logic              rst_in,             // Synchronous reset, active high.
  input  wire logic              cmd_valid_in,       // Command request.
  output logic                   cmd_ready_out,      // Controller can take a command.
  input  wire aasp_pkg::aasp_op_e cmd_op_in,         // Operation to run.
  input  wire logic [4:0]        cmd_addr_in,        // Register address.
  input  wire logic [7:0]        cmd_data_in,        // Value for a register write.
  input  wire logic [4:0]        cmd_bits_in,        // Clocks for an angle read, 1 to 16.
  output logic                   rsp_valid_out,      // One-cycle result strobe.
  output logic [15:0]            rsp_angle_out,      // Angle, left aligned.
  output logic [7:0]             rsp_data_out,       // Register value or acknowledge.
  output logic                   rsp_match_out,      // Acknowledge equals written value.
  output logic                   rsp_refused_out,    // Command was refused, nothing sent.
  output logic                   nvm_busy_out,       // Synchronised memory busy level.
  output logic                   spi_cs_n_out,       // Chip select, active low.
  output logic                   spi_sclk_out,       // Serial clock.
  output logic                   spi_mosi_out,       // Serial data to the sensor.
  input  wire logic              spi_miso_in,        // Serial data from the sensor.
  input  wire logic              memory_busy_pin_in  // Sensor memory busy pin.
);
  import aasp_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_NVM_WAIT, S_FRAME1, S_FRAME2} aasp_st_e;
  typedef struct packed {
    aasp_st_e    st;
    aasp_op_e    op;
    logic [4:0]  addr;
    logic [7:0]  data;
    aasp_bits_t  bits;
    aasp_cnt8_t  guard;
    logic [31:0] dirty;
    logic        start;
    aasp_word_t  tx;
    aasp_bits_t  fbits;
    logic        rsp_valid;
    aasp_word_t  angle;
    logic [7:0]  value;
    logic        match;
    logic        refused;
  } aasp_top_s;

  localparam aasp_cnt8_t GUARD_C  = aasp_cnt8_t'(NVM_GUARD_CYC);
  localparam aasp_cnt8_t CNT_ONE  = 8'h01;
  localparam aasp_top_s  TOP_RST  = '{st: S_IDLE, op: OP_ANGLE, addr: '0, data: '0,
                                      bits: FULL_BITS, guard: '0, dirty: '0, start: 1'b0,
                                      tx: '0, fbits: FULL_BITS, rsp_valid: 1'b0,
                                      angle: '0, value: '0, match: 1'b0, refused: 1'b0};

  aasp_top_s    s_reg;
  aasp_top_s    s_next;
  logic [1:0]   sync_lvl;
  logic         miso_s;
  logic         busy_s;
  aasp_bits_t   req_bits;
  aasp_frame_if fr ();

  // Builds the request frame: code first, then address, then value, MSB first.
  function automatic aasp_word_t frame_word(input aasp_op_e op, input logic [4:0] addr,
                                            input logic [7:0] data);
    aasp_word_t w;
    w = '0;
    unique case (op)
      OP_ANGLE:     w = {CODE_ANGLE, 13'h0000};
      OP_READ:      w = {CODE_READ, addr, 8'h00};
      OP_WRITE:     w = {CODE_WRITE, addr, data};
      OP_STORE_ONE: w = {CODE_STORE_ONE, addr, 8'h00};
      OP_STORE_ALL: w = {CODE_STORE_ALL, 13'h0000};
      OP_RESTORE:   w = {CODE_RESTORE, 13'h0000};
      OP_CLEAR:     w = {CODE_CLEAR, 13'h0000};
      default:      w = {CODE_ANGLE, 13'h0000};
    endcase
    return w;
  endfunction

  // Moves a partial angle to the top, so fewer clocks simply mean lower resolution.
  function automatic aasp_word_t align_angle(input aasp_word_t rx, input aasp_bits_t bits);
    return aasp_word_t'(rx << (FULL_BITS - bits));
  endfunction

  // The data-in and busy pins come from the sensor's side and are synchronised first.
  aasp_pin_sync #(
    .W (2)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .pins_in    ({memory_busy_pin_in, spi_miso_in}),
    .sync_out   (sync_lvl)
  );

  assign miso_s = sync_lvl[0];
  assign busy_s = sync_lvl[1];

  // The engine owns the pins; this level only schedules frames.
  aasp_frame_engine #(
    .SCLK_HALF     (SCLK_HALF),
    .CLK_IDLE_HIGH (CLK_IDLE_HIGH)
  ) u_engine (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .fr           (fr.engine),
    .spi_cs_n_out (spi_cs_n_out),
    .spi_sclk_out (spi_sclk_out),
    .spi_mosi_out (spi_mosi_out)
  );

  assign fr.start  = s_reg.start;
  assign fr.nbits  = s_reg.fbits;
  assign fr.tx     = s_reg.tx;
  assign fr.miso_s = miso_s;

  // Out-of-range clock counts fall back to a full sixteen-clock read.
  assign req_bits = ((cmd_bits_in == '0) || (cmd_bits_in > FULL_BITS))
                    ? FULL_BITS : cmd_bits_in;

  // Command sequencer. The dirty mask marks registers written since the last store or restore;
  // storing a register that was never written would only save what memory holds.
  always_comb
  begin
    s_next           = s_reg;
    s_next.start     = 1'b0;
    s_next.rsp_valid = 1'b0;
    if (s_reg.guard != '0)
    begin
      s_next.guard = s_reg.guard - CNT_ONE;
    end
    unique case (s_reg.st)
      S_IDLE:
      begin
        if (cmd_valid_in)
        begin
          s_next.op      = cmd_op_in;
          s_next.addr    = cmd_addr_in;
          s_next.data    = cmd_data_in;
          s_next.bits    = (cmd_op_in == OP_ANGLE) ? req_bits : FULL_BITS;
          s_next.refused = 1'b0;
          s_next.match   = 1'b0;
          if (((cmd_op_in == OP_STORE_ONE) && !s_reg.dirty[cmd_addr_in]) ||
              ((cmd_op_in == OP_STORE_ALL) && (s_reg.dirty == '0)))
          begin
            s_next.rsp_valid = 1'b1;
            s_next.refused   = 1'b1;
            s_next.angle     = '0;
            s_next.value     = '0;
          end
          else if (is_nvm_op(cmd_op_in))
          begin
            s_next.st = S_NVM_WAIT;
          end
          else
          begin
            s_next.st    = S_FRAME1;
            s_next.start = 1'b1;
            s_next.tx    = frame_word(cmd_op_in, cmd_addr_in, cmd_data_in);
            s_next.fbits = s_next.bits;
          end
        end
      end
      S_NVM_WAIT:
      begin
        // The guard covers the busy pin's rise and its synchroniser delay.
        if ((s_reg.guard == '0) && !busy_s)
        begin
          s_next.st    = S_FRAME1;
          s_next.start = 1'b1;
          s_next.tx    = frame_word(s_reg.op, s_reg.addr, s_reg.data);
          s_next.fbits = FULL_BITS;
        end
      end
      S_FRAME1:
      begin
        if (fr.done)
        begin
          if (is_two_frame(s_reg.op))
          begin
            s_next.st    = S_FRAME2;
            s_next.start = 1'b1;
            s_next.tx    = '0;
            s_next.fbits = FULL_BITS;
          end
          else
          begin
            s_next.st        = S_IDLE;
            s_next.rsp_valid = 1'b1;
            s_next.angle     = align_angle(fr.rx, s_reg.bits);
            s_next.value     = '0;
            s_next.match     = 1'b1;
            if (is_nvm_op(s_reg.op))
            begin
              s_next.guard = GUARD_C;
            end
            if (s_reg.op == OP_STORE_ONE)
            begin
              s_next.dirty[s_reg.addr] = 1'b0;
            end
            else if ((s_reg.op == OP_STORE_ALL) || (s_reg.op == OP_RESTORE))
            begin
              s_next.dirty = '0;
            end
          end
        end
      end
      S_FRAME2:
      begin
        if (fr.done)
        begin
          s_next.st        = S_IDLE;
          s_next.rsp_valid = 1'b1;
          s_next.angle     = {fr.rx[FRAME_BITS-1:ADDR_LSB], 8'h00};
          s_next.value     = fr.rx[DATA_MSB:0];
          s_next.match     = (s_reg.op != OP_WRITE) || (fr.rx[DATA_MSB:0] == s_reg.data);
          if ((s_reg.op == OP_WRITE) && s_next.match)
          begin
            s_next.dirty[s_reg.addr] = 1'b1;
          end
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s_reg <= TOP_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // The ready handshake is combinational; all data outputs come from flip-flops.
  assign cmd_ready_out   = (s_reg.st == S_IDLE);
  assign rsp_valid_out   = s_reg.rsp_valid;
  assign rsp_angle_out   = s_reg.angle;
  assign rsp_data_out    = s_reg.value;
  assign rsp_match_out   = s_reg.match;
  assign rsp_refused_out = s_reg.refused;
  assign nvm_busy_out    = busy_s;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  AST_READ_REQ:
    assert property (fr.start && (s_reg.st == S_FRAME1) && (s_reg.op == OP_READ)
                     |-> fr.tx == {CODE_READ, s_reg.addr, 8'h00} && fr.nbits == FULL_BITS)
    else $error("read request frame malformed");

  AST_RESP_ZERO:
    assert property ((s_reg.st == S_FRAME2) && !spi_cs_n_out |-> !spi_mosi_out)
    else $error("data-out not zero during response frame");

  AST_TWO_FRAMES:
    assert property ((s_reg.st == S_FRAME1) && fr.done && is_two_frame(s_reg.op)
                     |=> fr.start && (s_reg.st == S_FRAME2) ##1 !cmd_ready_out)
    else $error("second frame did not follow request frame");

  AST_WRITE_REQ:
    assert property (fr.start && (s_reg.st == S_FRAME1) && (s_reg.op == OP_WRITE)
                     |-> fr.tx == {CODE_WRITE, s_reg.addr, s_reg.data})
    else $error("write request frame malformed");

  AST_STORE_WRITTEN:
    assert property (fr.start && (s_reg.st == S_FRAME1) && (s_reg.op == OP_STORE_ONE)
                     |-> s_reg.dirty[s_reg.addr])
    else $error("store of a register never written");

  AST_NVM_FREE:
    assert property (fr.start && (s_reg.st == S_FRAME1) && is_nvm_op(s_reg.op)
                     |-> !$past(busy_s) && ($past(s_reg.guard) == '0))
    else $error("memory command sent while busy");

  AST_STORE_ONE_CODE:
    assert property (fr.start && (s_reg.op == OP_STORE_ONE)
                     |-> fr.tx[CODE_MSB:CODE_LSB] == CODE_STORE_ONE
                         && fr.tx[ADDR_MSB:ADDR_LSB] == s_reg.addr)
    else $error("store single frame malformed");

  AST_STORE_ALL_CODE:
    assert property (fr.start && (s_reg.op == OP_STORE_ALL)
                     |-> fr.tx == {CODE_STORE_ALL, 13'h0000})
    else $error("store all frame malformed");

  AST_RESTORE_CODE:
    assert property (fr.start && (s_reg.op == OP_RESTORE)
                     |-> fr.tx == {CODE_RESTORE, 13'h0000})
    else $error("restore frame malformed");
endmodule

// ===== dv/aasp_sensor_model.sv
// Behavioural angle sensor on the far side of the SPI link.
`timescale 1ns/1ns
module aasp_sensor_model #(
  parameter int BUSY_NS = 3000 // Memory busy time, shortened.
) (
  input  wire logic cs_n_in,  // Chip select, active low.
  input  wire logic sclk_in,  // Serial clock.
  input  wire logic mosi_in,  // Serial data in.
  output logic      miso_out, // Serial data out.
  output logic      busy_out  // Memory busy pin.
);
  logic [15:0] angle = 16'h1357;
  logic [15:0] frz;
  logic [15:0] sh;
  logic [15:0] rx;
  logic [7:0]  regs [32];
  logic [7:0]  memory_busy_pin [32];
  logic [7:0]  rv;
  logic        pend = 1'b0;
  int          n;
  int          n_ign = 0;
  // Power-up copies the memory image into the working registers.
  initial
  begin
    foreach (memory_busy_pin[i]) memory_busy_pin[i] = 8'h3c;
    regs = memory_busy_pin;
    regs[26] = 8'h0e;
    busy_out = 1'b0;
    miso_out = 1'b0;
  end
  // A fresh sample every microsecond; a frame keeps its frozen copy.
  always #1000 angle = angle + 16'h0b1d;
  // Chip select fall freezes the buffer and presents the first bit.
  always @(negedge cs_n_in)
  begin
    frz = angle;
    sh = pend ? {angle[15:8], rv} : angle;
    miso_out = sh[15];
    n = 0;
  end
  // Data is taken on the rise and shifted out on the fall. A fall before the first
  // rise is the mode 3 lead-in and must not move the bit shown at chip select fall.
  always @(posedge sclk_in)
    if (!cs_n_in)
    begin
      rx = {rx[14:0], mosi_in};
      n++;
    end
  always @(negedge sclk_in)
    if (!cs_n_in && n > 0)
    begin
      sh = sh << 1;
      miso_out = sh[15];
    end
  // Memory work holds the busy pin high for its whole duration.
  task automatic mem_op(input logic [2:0] c, input logic [4:0] ad);
    busy_out = 1'b1;
    if (c == 3'h7) memory_busy_pin[ad] = regs[ad];
    if (c == 3'h6) memory_busy_pin = regs;
    if (c == 3'h5) regs = memory_busy_pin;
    #(BUSY_NS) busy_out = 1'b0;
  endtask
  // Only whole frames are decoded; the released line shows the inverse level.
  always @(posedge cs_n_in)
  begin
    miso_out = ~miso_out;
    if (n == 16 && rx[15:13] == 3'h4) regs[rx[12:8]] = rx[7:0];
    if (n == 16 && rx[15:13] == 3'h1) regs[26] = 8'h00;
    rv = regs[rx[12:8]];
    pend = (n == 16) && (rx[15:13] inside {3'h2, 3'h4});
    if (n == 16 && rx[15:13] >= 3'h5 && busy_out) n_ign++;
    else if (n == 16 && rx[15:13] >= 3'h5)
      fork
        mem_op(rx[15:13], rx[12:8]);
      join_none
  end
endmodule

// ===== dv/test_angle_sensor_spi_command_port.sv
// Self-checking bench of the angle sensor SPI host controller.
`timescale 1ns/1ns
module test_angle_sensor_spi_command_port;
  import aasp_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cmd_valid_in = 1'b0;
  aasp_op_e    cmd_op_in = OP_ANGLE;
  logic [4:0]  cmd_addr_in = 5'h00;
  logic [4:0]  cmd_bits_in = 5'h00;
  logic [7:0]  cmd_data_in = 8'h00;
  logic        cmd_ready_out, rsp_valid_out, rsp_match_out, rsp_refused_out, nvm_busy_out;
  logic [15:0] rsp_angle_out;
  logic [7:0]  rsp_data_out;
  logic        spi_cs_n_out, spi_sclk_out, spi_mosi_out, spi_miso_in, memory_busy_pin_in;
  logic        rsp3_valid, spi3_cs_n, spi3_sclk, spi3_mosi, spi3_miso, pin3_busy;
  logic [15:0] rsp3_angle;
  logic [7:0]  rsp3_data;
  int          n_fail = 0;
  int          checked = 0;
  aasp_host_ctrl dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_bits_in(cmd_bits_in),
    .rsp_valid_out(rsp_valid_out), .rsp_angle_out(rsp_angle_out),
    .rsp_data_out(rsp_data_out), .rsp_match_out(rsp_match_out),
    .rsp_refused_out(rsp_refused_out), .nvm_busy_out(nvm_busy_out),
    .spi_cs_n_out(spi_cs_n_out), .spi_sclk_out(spi_sclk_out), .spi_mosi_out(spi_mosi_out),
    .spi_miso_in(spi_miso_in), .memory_busy_pin_in(memory_busy_pin_in));
  // A second controller in clock mode 3 runs the same commands in lockstep with its own sensor.
  aasp_host_ctrl #(.CLK_IDLE_HIGH(1'b1)) dut3_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_bits_in(cmd_bits_in),
    .rsp_valid_out(rsp3_valid), .rsp_angle_out(rsp3_angle), .rsp_data_out(rsp3_data),
    .rsp_match_out(), .rsp_refused_out(), .nvm_busy_out(), .spi_cs_n_out(spi3_cs_n),
    .spi_sclk_out(spi3_sclk), .spi_mosi_out(spi3_mosi), .spi_miso_in(spi3_miso),
    .memory_busy_pin_in(pin3_busy));
  aasp_sensor_model m3_u (.cs_n_in(spi3_cs_n), .sclk_in(spi3_sclk), .mosi_in(spi3_mosi),
    .miso_out(spi3_miso), .busy_out(pin3_busy));
  aasp_sensor_model m_u (.cs_n_in(spi_cs_n_out), .sclk_in(spi_sclk_out),
    .mosi_in(spi_mosi_out), .miso_out(spi_miso_in), .busy_out(memory_busy_pin_in));
  // Core clock at 10 MHz.
  always #50 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until taken, then waits a bounded time for the result.
  task automatic run(input aasp_op_e op, input logic [4:0] ad, input logic [7:0] d,
                     input logic [4:0] b);
    int i;
    cmd_op_in = op;
    cmd_addr_in = ad;
    cmd_data_in = d;
    cmd_bits_in = b;
    cmd_valid_in = 1'b1;
    // Ready is read off the edge, where it is settled; it then holds through the taking edge.
    while (cmd_ready_out !== 1'b1) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    for (i = 0; i < 3000 && rsp_valid_out !== 1'b1; i++) @(negedge ref_clk_in);
    chk(16'(rsp_valid_out), 16'h0001);
    chk(16'(rsp3_valid), 16'h0001);
  endtask
  task automatic t_angle();
    run(OP_ANGLE, 5'h00, 8'h00, 5'h10);
    chk(rsp_angle_out, m_u.frz);
    chk(rsp3_angle, m3_u.frz);
    run(OP_ANGLE, 5'h00, 8'h00, 5'h08);
    chk(rsp_angle_out, {m_u.frz[15:8], 8'h00});
    chk(rsp3_angle, {m3_u.frz[15:8], 8'h00});
    $display("angle reads done");
  endtask
  task automatic t_regs();
    run(OP_WRITE, 5'h09, 8'h80, 5'h00);
    chk(16'(rsp_data_out), 16'h0080);
    chk(16'(rsp_match_out), 16'h0001);
    run(OP_READ, 5'h09, 8'h00, 5'h00);
    chk(16'(rsp_data_out), 16'h0080);
    chk(rsp_angle_out, {m_u.frz[15:8], 8'h00});
    chk(16'(rsp3_data), 16'h0080);
    run(OP_CLEAR, 5'h00, 8'h00, 5'h00);
    chk(rsp_angle_out, m_u.frz);
    run(OP_READ, 5'h1a, 8'h00, 5'h00);
    chk(16'(rsp_data_out), 16'h0000);
    $display("register access done");
  endtask
  task automatic t_nvm();
    run(OP_STORE_ONE, 5'h03, 8'h00, 5'h00);
    chk(16'(rsp_refused_out), 16'h0001);
    run(OP_STORE_ONE, 5'h09, 8'h00, 5'h00);
    chk(rsp_angle_out, m_u.frz);
    repeat (3) @(negedge ref_clk_in);
    chk(16'(nvm_busy_out), 16'h0001);
    run(OP_STORE_ALL, 5'h00, 8'h00, 5'h00);
    chk(16'(rsp_refused_out), 16'h0001);
    run(OP_WRITE, 5'h09, 8'h55, 5'h00);
    run(OP_RESTORE, 5'h00, 8'h00, 5'h00);
    chk(rsp_angle_out, m_u.frz);
    run(OP_READ, 5'h09, 8'h00, 5'h00);
    chk(16'(rsp_data_out), 16'h0080);
    run(OP_WRITE, 5'h09, 8'h21, 5'h00);
    run(OP_STORE_ALL, 5'h00, 8'h00, 5'h00);
    chk(16'(m_u.memory_busy_pin[9]), 16'h0021);
    chk(16'(m_u.n_ign), 16'h0000);
    $display("memory commands done");
  endtask
  task automatic print_verdict();
    $display("Counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog sized well above the expected run of a little over a hundred microseconds.
  initial
  begin
    #3000000;
    n_fail++;
    print_verdict();
  end
  // Main sequence after five cycles of reset.
  initial
  begin
    repeat (5) @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_angle();
    t_regs();
    t_nvm();
    print_verdict();
  end
endmodule
